// File: inc/ocmp_defs.svh
// Constants of the output compare channel: offsets, fields, resets, codes.
// Assumes byte addressing on a 32-bit AXI4-Lite bus, one word per register.
`ifndef OCMP_DEFS_SVH
`define OCMP_DEFS_SVH

// Register byte offsets
`define OCMP_OFF_CTRL 8'h00
`define OCMP_OFF_PRI 8'h04
`define OCMP_OFF_SEC 8'h08
`define OCMP_OFF_STAT 8'h0c
`define OCMP_OFF_MASK 8'h10

// Control register field positions
`define OCMP_BIT_IDLE 13
`define OCMP_BIT_FLT 4
`define OCMP_BIT_TSEL 3
`define OCMP_MODE_MSB 2
`define OCMP_MODE_LSB 0

// Event bit positions in status and mask
`define OCMP_EVT_CMP 0
`define OCMP_EVT_FLT 1

// Reset values
`define OCMP_CTRL_RST 16'h0000
`define OCMP_CMP_RST 16'h0000
`define OCMP_EVT_RST 2'h0

// Bus answers
`define OCMP_RESP_OKAY 2'h0
`define OCMP_RESP_SLVERR 2'h2

`endif

// File: inc/ocmp_pkg.sv
// Types used by the output compare channel; its match detector uses none of them.
// Assumes the constants header is compiled alongside.
package ocmp_pkg;

  // Mode field encodings
  typedef enum logic [2:0] {
    MODE_OFF = 3'h0,
    MODE_ONE_HIGH = 3'h1,
    MODE_ONE_LOW = 3'h2,
    MODE_TOGGLE = 3'h3,
    MODE_DELAYED = 3'h4,
    MODE_CONT = 3'h5,
    MODE_PWM = 3'h6,
    MODE_PWM_FLT = 3'h7
  } compare_mode_t;

  // Pulse sequencer, Gray coded along rise, fall, done
  typedef enum logic [1:0] {
    PH_RISE = 2'h0,
    PH_FALL = 2'h1,
    PH_DONE = 2'h3
  } pulse_phase_t;

  typedef struct packed {
    logic halt_in_idle;
    logic pwm_fault_flag;
    logic time_base_select;
    compare_mode_t compare_mode_field;
  } ctrl_t;

  typedef struct packed {
    logic fault;
    logic compare;
  } evt_t;

endpackage

// File: hdl/match_detect.sv
// Selects one of two shared timers and flags the first cycle it equals a value.
// Assumes timer counts are synchronous to clk and may hold over many cycles.
`timescale 1ns/1ns
module match_detect #(
  parameter int WIDTH = 16
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic enable,
  input wire logic time_base_select,
  input wire logic [WIDTH-1:0] first_shared_timer,
  input wire logic [WIDTH-1:0] second_shared_timer,
  input wire logic [WIDTH-1:0] compare_value,
  output logic hit
);

  logic eq_ff;
  logic hit_ff;
  logic nxt_eq;
  logic nxt_hit;

  // Equality edge, so a timer held by its prescaler matches only once
  always_comb begin
    nxt_eq = (time_base_select ? second_shared_timer : first_shared_timer) == compare_value;
    nxt_hit = enable && nxt_eq && !eq_ff;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      eq_ff <= 1'b0;
      hit_ff <= 1'b0;
    end else begin
      eq_ff <= nxt_eq;
      hit_ff <= nxt_hit;
    end
  end

  assign hit = hit_ff;

endmodule

// File: hdl/output_compare_pwm.sv
// One output compare channel with PWM, behind an AXI4-Lite register slave.
// Assumes shared timers, rollover pulses, idle and fault inputs are synchronous to clk.
`timescale 1ns/1ns
`include "ocmp_defs.svh"

// Functional notes
// - Time select bit picks second or first timer
// - Compare against one or two values per mode
// - Match changes output as mode prescribes
// - Mode zero: disabled, pin released, no interrupt
// - Mode 1: start low, match sets high
// - Mode 2: start high, match forces low
// - Mode 3: keep level, toggle each match
// - Mode 4: one pulse between two matches
// - Mode 5: repeating pulses, interrupt on falls
// - Mode 6: PWM, start by primary nonzero
// - Mode 7: PWM, interrupt on fault falling edge
// - Fault flag set in mode 7, a control write clears
// - Halt in idle when halt bit set
// - Only channels zero and one request DMA
// - Unimplemented control bits read zero, reset zero
module output_compare_pwm #(
  parameter int CHANNEL_INDEX = 0,
  parameter int WIDTH = 16
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic [WIDTH-1:0] first_shared_timer,
  input wire logic [WIDTH-1:0] second_shared_timer,
  input wire logic first_timer_rollover,
  input wire logic second_timer_rollover,
  input wire logic cpu_idle,
  input wire logic shared_fault_input,
  output logic compare_output_pin,
  output logic compare_output_enable,
  output logic irq,
  output logic dma_request
);

  // Bus state
  logic aw_hold_ff, nxt_aw_hold, w_hold_ff, nxt_w_hold;
  logic awready_ff, nxt_awready, wready_ff, nxt_wready, arready_ff, nxt_arready;
  logic bvalid_ff, nxt_bvalid, rvalid_ff, nxt_rvalid;
  logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
  logic [7:0] awaddr_ff, nxt_awaddr;
  logic [31:0] wdata_ff, nxt_wdata, rdata_ff, nxt_rdata;
  logic [3:0] wstrb_ff, nxt_wstrb;
  logic commit, wr_ctrl, wr_pri, wr_sec, wr_stat, wr_mask;
  logic [15:0] wr_val, ctrl_word;

  // Channel state
  ocmp_pkg::ctrl_t ctrl_ff, nxt_ctrl;
  ocmp_pkg::pulse_phase_t phase_ff, nxt_phase;
  ocmp_pkg::evt_t status_ff, nxt_status, mask_ff, nxt_mask, evt;
  logic [WIDTH-1:0] pri_ff, nxt_pri, sec_ff, nxt_sec, duty_ff, nxt_duty, sec_target;
  logic pin_ff, nxt_pin, out_en_ff, nxt_out_en, irq_ff, nxt_irq, dma_ff, nxt_dma;
  logic fault_prev_ff, nxt_fault_prev;
  logic run, rollover, pwm_mode, hit_pri, hit_sec, fault_fall;

  // Merge a bus word into a 16-bit register honouring byte strobes
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  // Unimplemented bits stay zero in the readable image
  always_comb begin
    ctrl_word = `OCMP_CTRL_RST;
    ctrl_word[`OCMP_BIT_IDLE] = ctrl_ff.halt_in_idle;
    ctrl_word[`OCMP_BIT_FLT] = ctrl_ff.pwm_fault_flag;
    ctrl_word[`OCMP_BIT_TSEL] = ctrl_ff.time_base_select;
    ctrl_word[`OCMP_MODE_MSB:`OCMP_MODE_LSB] = ctrl_ff.compare_mode_field;
  end

  // AXI4-Lite slave: address and data taken in any order, write done one edge later
  always_comb begin
    commit = aw_hold_ff && w_hold_ff && !bvalid_ff;
    nxt_awaddr = awaddr_ff;
    nxt_wdata = wdata_ff;
    nxt_wstrb = wstrb_ff;
    nxt_aw_hold = aw_hold_ff;
    nxt_w_hold = w_hold_ff;
    if (awvalid && awready_ff) begin
      nxt_aw_hold = 1'b1;
      nxt_awaddr = awaddr;
    end
    if (wvalid && wready_ff) begin
      nxt_w_hold = 1'b1;
      nxt_wdata = wdata;
      nxt_wstrb = wstrb;
    end
    wr_ctrl = commit && awaddr_ff == `OCMP_OFF_CTRL;
    wr_pri = commit && awaddr_ff == `OCMP_OFF_PRI;
    wr_sec = commit && awaddr_ff == `OCMP_OFF_SEC;
    wr_stat = commit && awaddr_ff == `OCMP_OFF_STAT;
    wr_mask = commit && awaddr_ff == `OCMP_OFF_MASK;
    wr_val = merge16(wr_ctrl ? ctrl_word : wr_pri ? 16'(pri_ff) : wr_sec ? 16'(sec_ff) :
                     (wr_mask ? 16'(mask_ff) : 16'h0000), wdata_ff, wstrb_ff);
    nxt_bresp = bresp_ff;
    nxt_bvalid = bvalid_ff && !bready;
    if (commit) begin
      nxt_aw_hold = 1'b0;
      nxt_w_hold = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp = (wr_ctrl || wr_pri || wr_sec || wr_stat || wr_mask) ?
                  `OCMP_RESP_OKAY : `OCMP_RESP_SLVERR;
    end
    nxt_awready = !nxt_aw_hold && !nxt_bvalid;
    nxt_wready = !nxt_w_hold && !nxt_bvalid;
    // Read path answers on the same edge that takes the address
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    nxt_rvalid = rvalid_ff && !rready;
    if (arvalid && arready_ff) begin
      nxt_rvalid = 1'b1;
      nxt_rresp = `OCMP_RESP_OKAY;
      unique case (araddr)
        `OCMP_OFF_CTRL: nxt_rdata = {16'h0000, ctrl_word};
        `OCMP_OFF_PRI: nxt_rdata = 32'(pri_ff);
        `OCMP_OFF_SEC: nxt_rdata = 32'(sec_ff);
        `OCMP_OFF_STAT: nxt_rdata = {30'h0000_0000, status_ff};
        `OCMP_OFF_MASK: nxt_rdata = {30'h0000_0000, mask_ff};
        default: begin
          nxt_rdata = 32'h0000_0000;
          nxt_rresp = `OCMP_RESP_SLVERR;
        end
      endcase
    end
    nxt_arready = !nxt_rvalid;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      aw_hold_ff <= 1'b0;
      w_hold_ff <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      arready_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      bresp_ff <= `OCMP_RESP_OKAY;
      rresp_ff <= `OCMP_RESP_OKAY;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      rdata_ff <= 32'h0000_0000;
    end else begin
      aw_hold_ff <= nxt_aw_hold;
      w_hold_ff <= nxt_w_hold;
      awready_ff <= nxt_awready;
      wready_ff <= nxt_wready;
      arready_ff <= nxt_arready;
      bvalid_ff <= nxt_bvalid;
      rvalid_ff <= nxt_rvalid;
      bresp_ff <= nxt_bresp;
      rresp_ff <= nxt_rresp;
      awaddr_ff <= nxt_awaddr;
      wdata_ff <= nxt_wdata;
      wstrb_ff <= nxt_wstrb;
      rdata_ff <= nxt_rdata;
    end
  end

  // Match detectors; in PWM the second one tracks the latched duty
  assign pwm_mode = ctrl_ff.compare_mode_field[2] && ctrl_ff.compare_mode_field[1];
  assign sec_target = pwm_mode ? duty_ff : sec_ff;
  assign run = !(ctrl_ff.halt_in_idle && cpu_idle);
  assign rollover = ctrl_ff.time_base_select ? second_timer_rollover : first_timer_rollover;

  match_detect #(.WIDTH(WIDTH)) pri_match (
    .clk(clk),
    .reset(reset),
    .enable(run),
    .time_base_select(ctrl_ff.time_base_select),
    .first_shared_timer(first_shared_timer),
    .second_shared_timer(second_shared_timer),
    .compare_value(pri_ff),
    .hit(hit_pri)
  );

  match_detect #(.WIDTH(WIDTH)) sec_match (
    .clk(clk),
    .reset(reset),
    .enable(run),
    .time_base_select(ctrl_ff.time_base_select),
    .first_shared_timer(first_shared_timer),
    .second_shared_timer(second_shared_timer),
    .compare_value(sec_target),
    .hit(hit_sec)
  );

  // Output sequencing per mode; a control write re-initialises the pin
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_phase = phase_ff;
    nxt_pin = pin_ff;
    nxt_duty = duty_ff;
    nxt_pri = wr_pri ? WIDTH'(wr_val) : pri_ff;
    nxt_sec = wr_sec ? WIDTH'(wr_val) : sec_ff;
    nxt_fault_prev = shared_fault_input;
    evt = '0;
    fault_fall = fault_prev_ff && !shared_fault_input;
    if (wr_ctrl) begin
      nxt_ctrl.halt_in_idle = wr_val[`OCMP_BIT_IDLE];
      nxt_ctrl.time_base_select = wr_val[`OCMP_BIT_TSEL];
      nxt_ctrl.compare_mode_field =
        ocmp_pkg::compare_mode_t'(wr_val[`OCMP_MODE_MSB:`OCMP_MODE_LSB]);
      nxt_ctrl.pwm_fault_flag = 1'b0;
      nxt_phase = ocmp_pkg::PH_RISE;
      nxt_duty = pri_ff;
      unique case (nxt_ctrl.compare_mode_field)
        ocmp_pkg::MODE_OFF: nxt_pin = 1'b0;
        ocmp_pkg::MODE_ONE_HIGH: nxt_pin = 1'b0;
        ocmp_pkg::MODE_ONE_LOW: nxt_pin = 1'b1;
        ocmp_pkg::MODE_TOGGLE: nxt_pin = pin_ff;
        ocmp_pkg::MODE_DELAYED, ocmp_pkg::MODE_CONT: nxt_pin = 1'b0;
        ocmp_pkg::MODE_PWM, ocmp_pkg::MODE_PWM_FLT: nxt_pin = pri_ff != '0;
      endcase
    end else if (run) begin
      unique case (ctrl_ff.compare_mode_field)
        ocmp_pkg::MODE_OFF: nxt_pin = 1'b0;
        ocmp_pkg::MODE_ONE_HIGH: if (hit_pri && !pin_ff) begin
          nxt_pin = 1'b1;
          evt.compare = 1'b1;
        end
        ocmp_pkg::MODE_ONE_LOW: if (hit_pri && pin_ff) begin
          nxt_pin = 1'b0;
          evt.compare = 1'b1;
        end
        ocmp_pkg::MODE_TOGGLE: if (hit_pri) begin
          nxt_pin = !pin_ff;
          evt.compare = 1'b1;
        end
        ocmp_pkg::MODE_DELAYED, ocmp_pkg::MODE_CONT: begin
          // Rise on primary, fall on secondary; only continuous mode re-arms
          if (phase_ff == ocmp_pkg::PH_RISE && hit_pri) begin
            nxt_pin = 1'b1;
            nxt_phase = ocmp_pkg::PH_FALL;
          end else if (phase_ff == ocmp_pkg::PH_FALL && hit_sec) begin
            nxt_pin = 1'b0;
            evt.compare = 1'b1;
            nxt_phase = ctrl_ff.compare_mode_field == ocmp_pkg::MODE_CONT ?
                        ocmp_pkg::PH_RISE : ocmp_pkg::PH_DONE;
          end
        end
        ocmp_pkg::MODE_PWM, ocmp_pkg::MODE_PWM_FLT: begin
          // Rollover wins over a duty match so a full period stays high
          if (rollover) begin
            nxt_duty = sec_ff;
            nxt_pin = sec_ff != '0;
          end else if (hit_sec) begin
            nxt_pin = 1'b0;
          end
          if (ctrl_ff.compare_mode_field == ocmp_pkg::MODE_PWM_FLT) begin
            if (!shared_fault_input || ctrl_ff.pwm_fault_flag) nxt_pin = 1'b0;
          end
        end
      endcase
    end
    if (run && fault_fall && nxt_ctrl.compare_mode_field == ocmp_pkg::MODE_PWM_FLT) begin
      evt.fault = 1'b1;
      nxt_ctrl.pwm_fault_flag = 1'b1;
    end
    nxt_out_en = nxt_ctrl.compare_mode_field != ocmp_pkg::MODE_OFF;
    if (nxt_ctrl.compare_mode_field == ocmp_pkg::MODE_OFF) nxt_pin = 1'b0;
    // Sticky status: an event in the clearing cycle survives
    nxt_status = (wr_stat ? (status_ff & ~ocmp_pkg::evt_t'(wr_val[1:0])) : status_ff) | evt;
    nxt_mask = wr_mask ? ocmp_pkg::evt_t'(wr_val[1:0]) : mask_ff;
    nxt_irq = |(nxt_status & nxt_mask);
    nxt_dma = (CHANNEL_INDEX < 2) && evt.compare;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_ff <= ocmp_pkg::ctrl_t'(6'h00);
      phase_ff <= ocmp_pkg::PH_RISE;
      pin_ff <= 1'b0;
      out_en_ff <= 1'b0;
      duty_ff <= `OCMP_CMP_RST;
      pri_ff <= `OCMP_CMP_RST;
      sec_ff <= `OCMP_CMP_RST;
      status_ff <= `OCMP_EVT_RST;
      mask_ff <= `OCMP_EVT_RST;
      irq_ff <= 1'b0;
      dma_ff <= 1'b0;
      fault_prev_ff <= 1'b1;
    end else begin
      ctrl_ff <= nxt_ctrl;
      phase_ff <= nxt_phase;
      pin_ff <= nxt_pin;
      out_en_ff <= nxt_out_en;
      duty_ff <= nxt_duty;
      pri_ff <= nxt_pri;
      sec_ff <= nxt_sec;
      status_ff <= nxt_status;
      mask_ff <= nxt_mask;
      irq_ff <= nxt_irq;
      dma_ff <= nxt_dma;
      fault_prev_ff <= nxt_fault_prev;
    end
  end

  // Every output straight from a flip-flop
  assign awready = awready_ff;
  assign wready = wready_ff;
  assign bvalid = bvalid_ff;
  assign bresp = bresp_ff;
  assign arready = arready_ff;
  assign rvalid = rvalid_ff;
  assign rdata = rdata_ff;
  assign rresp = rresp_ff;
  assign compare_output_pin = pin_ff;
  assign compare_output_enable = out_en_ff;
  assign irq = irq_ff;
  assign dma_request = dma_ff;

  // Checks on channel behaviour
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_off_releases_pin: assert property (
    ctrl_ff.compare_mode_field == ocmp_pkg::MODE_OFF |-> !out_en_ff && !pin_ff && !evt.compare)
    else $error("disabled channel still drives pin");
  a_one_high_rise: assert property (
    run && !wr_ctrl && ctrl_ff.compare_mode_field == ocmp_pkg::MODE_ONE_HIGH && hit_pri && !pin_ff
    |=> pin_ff && status_ff.compare)
    else $error("one-shot high did not rise with interrupt");
  a_one_low_fall: assert property (
    run && !wr_ctrl && ctrl_ff.compare_mode_field == ocmp_pkg::MODE_ONE_LOW && hit_pri && pin_ff
    |=> !pin_ff && status_ff.compare)
    else $error("one-shot low did not fall with interrupt");
  a_toggle_flip: assert property (
    run && !wr_ctrl && ctrl_ff.compare_mode_field == ocmp_pkg::MODE_TOGGLE && hit_pri
    |=> pin_ff != $past(pin_ff))
    else $error("toggle mode did not invert the pin");
  a_delayed_done: assert property (
    ctrl_ff.compare_mode_field == ocmp_pkg::MODE_DELAYED && phase_ff == ocmp_pkg::PH_DONE
    && !wr_ctrl |=> !pin_ff && phase_ff == ocmp_pkg::PH_DONE)
    else $error("delayed one-shot pulsed twice");
  a_fault_forces_low: assert property (
    ctrl_ff.compare_mode_field == ocmp_pkg::MODE_PWM_FLT && !shared_fault_input && !wr_ctrl
    |=> !pin_ff)
    else $error("fault did not force output inactive");
  a_fault_flag_mode: assert property (
    $rose(ctrl_ff.pwm_fault_flag) |-> ctrl_ff.compare_mode_field == ocmp_pkg::MODE_PWM_FLT)
    else $error("fault flag set outside fault mode");
  a_idle_freeze: assert property (
    ctrl_ff.halt_in_idle && cpu_idle && !wr_ctrl |=> $stable(pin_ff))
    else $error("channel ran while halted in idle");
  a_dma_limited: assert property (
    CHANNEL_INDEX >= 2 |-> !dma_ff)
    else $error("DMA request from a channel without DMA");
  a_ctrl_reserved: assert property (
    arvalid && arready_ff && araddr == `OCMP_OFF_CTRL |=> rdata_ff[31:14] == '0 && rdata_ff[12:5] == '0)
    else $error("unimplemented control bits read nonzero");

  c_toggle_event: cover property (ctrl_ff.compare_mode_field == ocmp_pkg::MODE_TOGGLE && evt.compare);
  c_cont_pulse: cover property (ctrl_ff.compare_mode_field == ocmp_pkg::MODE_CONT && evt.compare);
  c_pwm_fault: cover property (evt.fault ##1 ctrl_ff.pwm_fault_flag);
  c_irq_raised: cover property ($rose(irq_ff));

endmodule

// File: testbench/pin_load.sv
// Load circuit on the compare output pin, plus the fault source.
// Assumes the pin and its enable are synchronous to clk.
`timescale 1ns/1ns
module pin_load (
  input wire logic clk,
  input wire logic pin,
  input wire logic pin_en,
  input wire logic clr,
  input wire logic fault_cmd,
  output logic shared_fault_input,
  output int rises,
  output int falls
);
  logic level;
  logic last_ff;
  // A released pin sits on the pull-down, never on its last driven value
  assign level = pin_en ? pin : 1'h0;
  // Open-drain fault line with pull-up, pulled low while a fault is commanded
  assign shared_fault_input = ~fault_cmd;
  // Count edges seen by the load
  always @(posedge clk) begin
    last_ff <= level;
    if (clr) begin
      rises <= 0;
      falls <= 0;
    end else begin
      if (level && !last_ff) rises <= rises + 1;
      if (!level && last_ff) falls <= falls + 1;
    end
  end
endmodule

// File: testbench/output_compare_pwm_tb.sv
// Self-checking bench for the output compare channel.
// Assumes the channel answers on AXI4-Lite and the bench owns both timers.
`timescale 1ns/1ns
`include "ocmp_defs.svh"
module output_compare_pwm_tb;
  logic clk, reset, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
  logic rvalid, rready, roll, run, cpu_idle, fault_cmd, clr, pin, pin_en, irq, dma, fault_n;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd_data;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, last_resp;
  logic [15:0] tmr, tmr_inv;
  int n_errors, n_compared, rises, falls, n_dma;
  // Second timer runs inverted so the two timers never agree
  assign tmr_inv = ~tmr;

  output_compare_pwm output_compare_pwm_inst (.clk(clk), .reset(reset), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .rresp(rresp), .first_shared_timer(tmr), .second_shared_timer(tmr_inv),
    .first_timer_rollover(roll), .second_timer_rollover(roll), .cpu_idle(cpu_idle),
    .shared_fault_input(fault_n), .compare_output_pin(pin), .compare_output_enable(pin_en),
    .irq(irq), .dma_request(dma));
  pin_load pin_load_inst (.clk(clk), .pin(pin), .pin_en(pin_en), .clr(clr),
    .fault_cmd(fault_cmd), .shared_fault_input(fault_n), .rises(rises), .falls(falls));

  // Clock at 100 MHz
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  // Period-16 timer that stands at zero while stopped
  always @(posedge clk) begin
    if (!run) begin
      tmr <= 16'h0000;
      roll <= 1'h0;
    end else begin
      tmr <= (tmr == 16'h000f) ? 16'h0000 : tmr + 16'h0001;
      roll <= (tmr == 16'h000f);
    end
  end
  // Transfer request pulses
  always @(posedge clk) begin
    if (clr) n_dma <= 0;
    else if (dma === 1'h1) n_dma <= n_dma + 1;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      n_errors++;
    end
  endtask
  // Write holds each channel until taken, then waits for the response; only the watchdog
  // ends a wait that never gets its answer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
    end while (!bvalid);
    last_resp = bresp;
    bready <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'h0;
    end while (!rvalid);
    rd_data = rdata;
    last_resp = rresp;
    rready <= 1'h0;
  endtask
  task automatic chk_rd(input string what, input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    chk(what, exp, rd_data);
  endtask
  // Timer is stopped whenever the control registers are written
  task automatic cfg(input logic [15:0] c, input logic [15:0] p, input logic [15:0] s);
    wr(`OCMP_OFF_PRI, {16'h0000, p});
    wr(`OCMP_OFF_SEC, {16'h0000, s});
    wr(`OCMP_OFF_STAT, 32'h0000_0003);
    wr(`OCMP_OFF_CTRL, {16'h0000, c});
    @(posedge clk);
    clr <= 1'h1;
    @(posedge clk);
    clr <= 1'h0;
    repeat (2) @(posedge clk);
  endtask
  task automatic spin(input int n);
    @(posedge clk);
    run <= 1'h1;
    repeat (n) @(posedge clk);
    run <= 1'h0;
    repeat (4) @(posedge clk);
  endtask
  task automatic edges(input int r, input int f, input logic p, input int dm);
    chk("rises", r, rises);
    chk("falls", f, falls);
    chk("pin", {31'h0000_0000, p}, {31'h0000_0000, pin});
    chk("dma", dm, n_dma);
  endtask

  task automatic t_regs;
    chk_rd("ctrl reset", `OCMP_OFF_CTRL, 32'h0000_0000);
    chk_rd("status reset", `OCMP_OFF_STAT, 32'h0000_0000);
    chk_rd("mask reset", `OCMP_OFF_MASK, 32'h0000_0000);
    wr(`OCMP_OFF_CTRL, 32'h0000_fff8);
    chk_rd("ctrl unimpl", `OCMP_OFF_CTRL, 32'h0000_2008);
    wr(`OCMP_OFF_MASK, 32'h0000_0003);
    chk_rd("mask", `OCMP_OFF_MASK, 32'h0000_0003);
    wr(8'h14, 32'h0000_0001);
    chk("wr resp", 32'(`OCMP_RESP_SLVERR), 32'(last_resp));
    chk_rd("unmapped", 8'h14, 32'h0000_0000);
    chk("rd resp", 32'(`OCMP_RESP_SLVERR), 32'(last_resp));
  endtask
  task automatic t_tsel;
    cfg(16'h0009, 16'hfffb, 16'h0009);
    spin(20);
    edges(1, 0, 1'h1, 1);
    cfg(16'h0009, 16'h0004, 16'h0009);
    spin(20);
    edges(0, 0, 1'h0, 0);
  endtask
  task automatic t_one_high;
    cfg(16'(ocmp_pkg::MODE_ONE_HIGH), 16'h0004, 16'h0009);
    chk("pin init", 0, pin);
    chk("enable on", 1, pin_en);
    spin(20);
    edges(1, 0, 1'h1, 1);
    chk_rd("status", `OCMP_OFF_STAT, 32'h0000_0001);
    chk("irq", 1, irq);
    wr(`OCMP_OFF_MASK, 32'h0000_0000);
    repeat (2) @(posedge clk);
    chk("irq masked", 0, irq);
    wr(`OCMP_OFF_MASK, 32'h0000_0003);
    wr(`OCMP_OFF_STAT, 32'h0000_0001);
    repeat (2) @(posedge clk);
    chk("irq cleared", 0, irq);
  endtask
  task automatic t_toggle;
    cfg(16'(ocmp_pkg::MODE_TOGGLE), 16'h0004, 16'h0009);
    chk("pin kept", 1, pin);
    // Idle with the halt bit clear must not stop the channel
    cpu_idle <= 1'h1;
    spin(32);
    cpu_idle <= 1'h0;
    edges(1, 1, 1'h1, 2);
  endtask
  task automatic t_one_low;
    cfg(16'(ocmp_pkg::MODE_ONE_LOW), 16'h0004, 16'h0009);
    chk("pin init", 1, pin);
    spin(20);
    edges(0, 1, 1'h0, 1);
  endtask
  task automatic t_delayed;
    cfg(16'(ocmp_pkg::MODE_DELAYED), 16'h0004, 16'h0009);
    spin(32);
    edges(1, 1, 1'h0, 1);
  endtask
  task automatic t_cont;
    cfg(16'(ocmp_pkg::MODE_CONT), 16'h0004, 16'h0009);
    spin(32);
    edges(2, 2, 1'h0, 2);
  endtask
  task automatic t_pwm;
    cfg(16'(ocmp_pkg::MODE_PWM), 16'h0000, 16'h0009);
    chk("pwm zero", 0, pin);
    cfg(16'(ocmp_pkg::MODE_PWM), 16'h0004, 16'h0009);
    chk("pwm init", 1, pin);
    spin(30);
    edges(1, 2, 1'h0, 0);
    chk_rd("pwm status", `OCMP_OFF_STAT, 32'h0000_0000);
  endtask
  task automatic t_fault;
    cfg(16'(ocmp_pkg::MODE_PWM_FLT), 16'h0004, 16'h0009);
    fault_cmd <= 1'h1;
    repeat (3) @(posedge clk);
    chk("fault pin", 0, pin);
    fault_cmd <= 1'h0;
    spin(20);
    edges(0, 1, 1'h0, 0);
    chk_rd("fault flag", `OCMP_OFF_CTRL, 32'h0000_0017);
    chk_rd("fault status", `OCMP_OFF_STAT, 32'h0000_0002);
    chk("fault irq", 1, irq);
    wr(`OCMP_OFF_CTRL, 32'h0000_0007);
    chk_rd("flag cleared", `OCMP_OFF_CTRL, 32'h0000_0007);
    repeat (2) @(posedge clk);
    chk("pin rearmed", 1, pin);
  endtask
  task automatic t_idle;
    cfg(16'h2001, 16'h0004, 16'h0009);
    cpu_idle <= 1'h1;
    spin(20);
    edges(0, 0, 1'h0, 0);
    cpu_idle <= 1'h0;
    spin(20);
    edges(1, 0, 1'h1, 1);
  endtask
  task automatic t_off;
    cfg(16'h0000, 16'h0004, 16'h0009);
    chk("enable", 0, pin_en);
    spin(20);
    edges(0, 0, 1'h0, 0);
    chk_rd("off status", `OCMP_OFF_STAT, 32'h0000_0000);
  endtask

  task automatic results;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Main sequence
  initial begin
    reset = 1'h1;
    {awvalid, wvalid, bready, arvalid, rready, run, cpu_idle, fault_cmd, clr} = 9'h000;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0000_0000;
    wstrb = 4'hf;
    n_errors = 0;
    n_compared = 0;
    repeat (3) @(posedge clk);
    reset <= 1'h0;
    t_regs;
    t_tsel;
    t_one_high;
    t_toggle;
    t_one_low;
    t_delayed;
    t_cont;
    t_pwm;
    t_fault;
    t_idle;
    t_off;
    results;
  end
  // Watchdog well beyond the several hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    results;
  end
endmodule
